// ### bench/esp_sram_model.sv
`timescale 1ns/1ps

// One-word static memory on the far side of the strobes.
module esp_sram_model
(
    input  wire logic        i_read_strobe_n,
    input  wire logic        i_store_strobe_n,
    input  wire logic        i_sel_n,
    input  wire logic [15:0] i_data,
    output logic      [15:0] o_data,
    output logic             o_data_oe
);
    logic [15:0] word_q = 16'h0000;  // Stored word.
    logic        wsel   = 1'b0;      // Select seen during the store.

    // Sampled just after the fall, since select moves on the same edge.
    always @(negedge i_store_strobe_n)
    begin
        #1 wsel = !i_sel_n;
    end

    // The word is taken only as the store strobe rises.
    always @(posedge i_store_strobe_n)
    begin
        if (wsel)
            word_q <= i_data;
    end

    assign o_data_oe = !i_read_strobe_n && !i_sel_n;
    assign o_data    = word_q;
endmodule

// ### bench/esp_strobe_ctrl_asserts.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Port-level checks of the strobe sequencer.
// ----------------------------------------------------------------------
module esp_strobe_ctrl_asserts
#(
    parameter int STROBE_CYCLES = esp_pkg::STROBE_CYC
)
(
    input wire logic        i_ref_clk,
    input wire logic        i_rst,
    input wire logic        i_bus_drive_select,
    input wire logic        i_strobe_pud,
    input wire logic [15:0] i_data,
    input wire logic        o_done,
    input wire logic [15:0] o_rd_data,
    input wire logic        o_req_ready,
    input wire logic [15:0] o_data,
    input wire logic [15:0] o_data_oe,
    input wire logic        o_read_strobe_n,
    input wire logic        o_store_strobe_n,
    input wire logic        o_strobe_oe,
    input wire logic        o_chip_select_zero_n,
    input wire logic        o_data_select_n,
    input wire logic        o_select_oe,
    input wire logic        o_strobe_pullup_en
);
    logic       lo_w;      // Either strobe is low.
    logic [7:0] lo_cnt_q;  // Low cycles of the current strobe.
    assign lo_w = !o_read_strobe_n || !o_store_strobe_n;

    // A counter, since the strobe length is a parameter.
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst || !lo_w)
            lo_cnt_q <= 8'h00;
        else
            lo_cnt_q <= lo_cnt_q + 8'h01;
    end

    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);

    rd_inputs_a: assert property (
        !o_read_strobe_n |-> o_data_oe[6:0] == 7'h00)
        else $error("data bus driven during read");
    rd_capture_a: assert property (
        $rose(o_read_strobe_n) |-> o_rd_data[6:0] == $past(i_data[6:0]))
        else $error("read data not taken at strobe rise");
    wr_drive_a: assert property (
        !o_store_strobe_n |-> o_data_oe[6:0] == 7'h7F && o_strobe_oe
        && o_select_oe) else $error("bus not driven during store");
    wr_hold_a: assert property (
        $rose(o_store_strobe_n) |-> o_data == $past(o_data)
        && o_data_oe[6:0] == 7'h7F) else $error("store data not held");
    strobe_len_a: assert property (
        $fell(lo_w) |-> lo_cnt_q == STROBE_CYCLES)
        else $error("strobe low time wrong");
    sel_qual_a: assert property (
        (!o_data_select_n || !o_chip_select_zero_n) |-> lo_w)
        else $error("select low without strobe");
    sel_excl_a: assert property (
        !(!o_data_select_n && !o_chip_select_zero_n))
        else $error("both selects low");
    idle_drive_a: assert property (
        o_req_ready && i_bus_drive_select && $past(i_bus_drive_select)
        |-> o_strobe_oe && o_select_oe && !lo_w && o_data_select_n
        && o_chip_select_zero_n) else $error("idle pins not held high");
    idle_float_a: assert property (
        o_req_ready && !i_bus_drive_select && !$past(i_bus_drive_select)
        |-> !o_strobe_oe && !o_select_oe && o_data_oe[6:0] == 7'h00)
        else $error("idle pins not floated");
    done_pulse_a: assert property (
        o_done |-> ($rose(o_read_strobe_n) || $rose(o_store_strobe_n))
        ##1 !o_done) else $error("done pulse misplaced");
    strobe_pu_a: assert property (
        1'b1 |=> o_strobe_pullup_en == !$past(i_strobe_pud))
        else $error("strobe pull-up control wrong");

    cover property ($rose(o_read_strobe_n));
    cover property ($rose(o_store_strobe_n));
    cover property (!o_chip_select_zero_n);
endmodule

bind esp_strobe_ctrl esp_strobe_ctrl_asserts
    #(.STROBE_CYCLES(STROBE_CYCLES)) u_asserts (.i_ref_clk, .i_rst,
    .i_bus_drive_select, .i_strobe_pud, .i_data, .o_done, .o_rd_data,
    .o_req_ready, .o_data, .o_data_oe, .o_read_strobe_n, .o_store_strobe_n,
    .o_strobe_oe, .o_chip_select_zero_n, .o_data_select_n, .o_select_oe,
    .o_strobe_pullup_en);

// ### bench/tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
    num_errors++; $display("wrong value %s exp %h got %h", nm, e, g); \
    end end

module tb;
    logic i_ref_clk = 1'b0, i_rst = 1'b1, i_req_valid = 1'b0;
    logic i_bus_drive_select = 1'b0, i_strobe_pud = 1'b0, role = 1'b1;
    logic i_cs0_role_wr = 1'b0, i_cs0_role = 1'b1;
    logic i_mode_wr = 1'b0, i_pullup_wr = 1'b0;
    logic [8:0] i_mode = 9'h000, i_pullup = 9'h1FF, o_port_f_in;
    logic [8:0] i_port_f_out = 9'h000, i_port_f_dir = 9'h000;
    logic [8:0] o_port_f_pullup_en;
    esp_pkg::esp_req_type i_req = '0;
    logic o_req_ready, o_done, o_read_strobe_n, o_store_strobe_n;
    logic o_strobe_oe, o_chip_select_zero_n, o_data_select_n;
    logic o_select_oe, o_strobe_pullup_en, mem_oe;
    logic [15:0] o_rd_data, o_data, o_data_oe, mem_q, mem_w = 16'h0000;
    wire  [15:0] i_data;
    integer seed = 32'hb204f629, num_errors = 0, tests_run = 0, cyc = 0;
    logic [31:0] r;

    // Driven lines win, then the memory, else the pull-ups.
    assign i_data = (o_data_oe & o_data)
                  | (~o_data_oe & (mem_oe ? mem_q : 16'hFFFF));

    esp_strobe_ctrl u_esp_strobe_ctrl (.i_ref_clk, .i_rst, .i_req_valid,
        .i_req, .o_req_ready, .o_done, .o_rd_data, .i_bus_drive_select,
        .i_cs0_role_wr, .i_cs0_role, .i_mode_wr, .i_mode, .i_pullup_wr,
        .i_pullup, .i_strobe_pud, .i_port_f_out, .i_port_f_dir,
        .o_port_f_in, .i_data, .o_data, .o_data_oe, .o_read_strobe_n,
        .o_store_strobe_n, .o_strobe_oe, .o_chip_select_zero_n,
        .o_data_select_n, .o_select_oe, .o_port_f_pullup_en,
        .o_strobe_pullup_en);

    esp_sram_model u_esp_sram_model (.i_read_strobe_n(o_read_strobe_n),
        .i_store_strobe_n(o_store_strobe_n),
        .i_sel_n(o_data_select_n & o_chip_select_zero_n),
        .i_data(i_data), .o_data(mem_q), .o_data_oe(mem_oe));

    initial forever #10 i_ref_clk = ~i_ref_clk;

    // A hang is cut short long after the fewer than two hundred cycles needed.
    always @(posedge i_ref_clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            num_errors++;
            finish_test;
        end
    end

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Expected {read, store, zero select, data select} while strobing.
    function automatic logic [3:0] exp_pins(input logic wr, pg, rl);
        return {wr, !wr, !(pg && rl), pg};
    endfunction

    // One access, held until taken, then checked through its end.
    task automatic access(input logic wr, pg, input logic [15:0] d);
        int n;
        logic [15:0] exp_rd;
        logic [3:0] pins;
        exp_rd = (pg && !role) ? 16'hFFFF : mem_w;
        @(posedge i_ref_clk);
        i_req_valid <= 1'b1;
        i_req <= {wr, pg, d};
        n = 0;
        do @(negedge i_ref_clk); while (o_req_ready !== 1'b1 && ++n < 20);
        @(posedge i_ref_clk);
        i_req_valid <= 1'b0;
        @(negedge i_ref_clk);
        pins = {o_read_strobe_n, o_store_strobe_n, o_chip_select_zero_n,
                o_data_select_n};
        `CHK("pins", exp_pins(wr, pg, role), pins)
        if (wr) `CHK("wdata", d, o_data)
        if (wr && !(pg && !role))
            mem_w = d;
        n = 0;
        while (o_done !== 1'b1 && n++ < 20) @(negedge i_ref_clk);
        `CHK("done", 1'b1, o_done)
        if (!wr) `CHK("rdata", exp_rd, o_rd_data)
    endtask

    task automatic set_role(input logic v);
        @(posedge i_ref_clk);
        i_cs0_role_wr <= 1'b1;
        i_cs0_role <= v;
        @(posedge i_ref_clk);
        i_cs0_role_wr <= 1'b0;
        role = v;
    endtask

    initial
    begin
        repeat (5) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        @(negedge i_ref_clk);
        `CHK("pullups", 9'h1FF, o_port_f_pullup_en)
        `CHK("strobe pullup", 1'b1, o_strobe_pullup_en)
        `CHK("idle oe", 2'b00, {o_strobe_oe, o_select_oe})
        `CHK("bus mode", 16'h0000, o_data_oe)
        $display("test reset done");
        access(1'b1, 1'b0, 16'hFFFF);
        access(1'b0, 1'b0, 16'h0000);
        for (int i = 0; i < 24; i++)
        begin
            r = $random(seed);
            @(posedge i_ref_clk);
            i_bus_drive_select <= r[0];
            access(r[1], r[2], r[18:3]);
        end
        $display("test random access done");
        set_role(1'b0);
        access(1'b1, 1'b1, 16'h1234);
        access(1'b0, 1'b1, 16'h0000);
        access(1'b0, 1'b0, 16'h0000);
        set_role(1'b1);
        access(1'b0, 1'b1, 16'h0000);
        $display("test zero select role done");
        @(posedge i_ref_clk);
        i_pullup_wr <= 1'b1;
        i_pullup <= 9'h0FE;
        i_strobe_pud <= 1'b1;
        i_bus_drive_select <= 1'b0;
        i_mode_wr <= 1'b1;
        i_mode <= 9'h101;
        i_port_f_dir <= 9'h001;
        @(posedge i_ref_clk);
        i_pullup_wr <= 1'b0;
        i_mode_wr <= 1'b0;
        repeat (3) @(negedge i_ref_clk);
        `CHK("pullups", 9'h0FE, o_port_f_pullup_en)
        `CHK("strobe pullup", 1'b0, o_strobe_pullup_en)
        `CHK("gpio oe", 1'b1, o_data_oe[7])
        `CHK("port f in", 9'h1FE, o_port_f_in)
        $display("test pins and pullups done");
        // Reset again with a read waiting: ready is low just after the
        // release, so the request must wait one more edge.
        @(posedge i_ref_clk);
        i_rst <= 1'b1;
        i_req_valid <= 1'b1;
        i_req <= {1'b0, 1'b0, 16'h0000};
        repeat (2) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        @(negedge i_ref_clk);
        `CHK("ready at release", 1'b0, o_req_ready)
        @(negedge i_ref_clk);
        `CHK("early strobe", 1'b1, o_read_strobe_n)
        `CHK("ready after release", 1'b1, o_req_ready)
        @(posedge i_ref_clk);
        i_req_valid <= 1'b0;
        repeat (3) @(negedge i_ref_clk);
        `CHK("done after reset", 1'b1, o_done)
        `CHK("rdata after reset", mem_w, o_rd_data)
        $display("test reset mid run done");
        finish_test;
    end
endmodule

// ### pkg/esp_pkg.sv
package esp_pkg;

    // ------------------------------------------------------------------
    // Bus geometry.
    // ------------------------------------------------------------------
    localparam int DATA_W    = 16;  // Full external data bus width.
    localparam int UPPER_W   = 9;   // Upper data lines shared with port F.
    localparam int UPPER_LSB = 7;   // Data line 7 is port F bit 0.

    // ------------------------------------------------------------------
    // Timing.
    // ------------------------------------------------------------------
    localparam int CLK_NS     = 20;  // Reference clock period in ns.
    localparam int STROBE_NS  = 40;  // Least strobe low time in ns.
    // Least time, so round up; never below one cycle.
    localparam int STROBE_CYC = ((STROBE_NS + CLK_NS - 1) / CLK_NS) < 1 ?
                                1 : ((STROBE_NS + CLK_NS - 1) / CLK_NS);
    localparam int CNT_W      = 8;   // Width of the strobe counter.

    // ------------------------------------------------------------------
    // Pin levels and reset values.
    // ------------------------------------------------------------------
    localparam logic STROBE_ON  = 1'b0;  // Strobes and selects, active.
    localparam logic STROBE_OFF = 1'b1;  // Strobes and selects, inactive.
    localparam logic [UPPER_W-1:0] PULLUP_RST = 9'h1FF;  // All enabled.
    localparam logic [UPPER_W-1:0] MODE_RST   = 9'h000;  // All data bus.
    localparam logic CS0_ROLE_PROG = 1'b1;  // Zero select = program sel.
    localparam logic [DATA_W-1:0]  DATA_RST   = 16'h0000;

    // ------------------------------------------------------------------
    // Access sequencer states.
    // ------------------------------------------------------------------
    typedef enum logic [1:0]
    {
        ST_IDLE   = 2'b00,
        ST_STROBE = 2'b01,
        ST_END    = 2'b10
    } esp_state_type;

    // One access request from the core side.
    typedef struct packed
    {
        logic              write;  // One for a store, zero for a read.
        logic              prog;   // One for program space, zero for data.
        logic [DATA_W-1:0] data;   // Store data, ignored on reads.
    } esp_req_type;

endpackage

// ### src/esp_strobe_ctrl.sv
`timescale 1ns/1ps

//------------------------------------------------------------------------
// Behaviour
// R1: Read strobe low, whole data bus input.
// R2: Read data latched as read strobe rises.
// R3: Store strobe low, data bus drives data.
// R4: Memory latches on store strobe rise.
// R5: Selects valid only while a strobe asserted.
// R6: Drive select chooses idle drive or float.
// R7: Program select low on program accesses.
// R8: Zero select acts as program select.
// R9: Upper pins reset to data bus mode.
// R10: Clear port F bit disables pull-up.
// R11: Set strobe bit disables strobe pull-ups.
// R12: Data select low on data accesses.
// R13: Idle driven strobes and selects stay high.
//------------------------------------------------------------------------
module esp_strobe_ctrl
#(
    parameter int STROBE_CYCLES = esp_pkg::STROBE_CYC
)
(
    // Clock and reset.
    input  wire logic                            i_ref_clk,
    input  wire logic                            i_rst,
    // Access request and answer.
    input  wire logic                            i_req_valid,
    input  wire esp_pkg::esp_req_type            i_req,
    output logic                                 o_req_ready,
    output logic                                 o_done,
    output logic [esp_pkg::DATA_W-1:0]           o_rd_data,
    // Configuration.
    input  wire logic                            i_bus_drive_select,
    input  wire logic                            i_cs0_role_wr,
    input  wire logic                            i_cs0_role,
    input  wire logic                            i_mode_wr,
    input  wire logic [esp_pkg::UPPER_W-1:0]     i_mode,
    input  wire logic                            i_pullup_wr,
    input  wire logic [esp_pkg::UPPER_W-1:0]     i_pullup,
    input  wire logic                            i_strobe_pud,
    // Port F.
    input  wire logic [esp_pkg::UPPER_W-1:0]     i_port_f_out,
    input  wire logic [esp_pkg::UPPER_W-1:0]     i_port_f_dir,
    output logic      [esp_pkg::UPPER_W-1:0]     o_port_f_in,
    // Data bus pins.
    input  wire logic [esp_pkg::DATA_W-1:0]      i_data,
    output logic      [esp_pkg::DATA_W-1:0]      o_data,
    output logic      [esp_pkg::DATA_W-1:0]      o_data_oe,
    // Strobe and select pins.
    output logic                                 o_read_strobe_n,
    output logic                                 o_store_strobe_n,
    output logic                                 o_strobe_oe,
    output logic                                 o_chip_select_zero_n,
    output logic                                 o_data_select_n,
    output logic                                 o_select_oe,
    // Pull-up controls.
    output logic      [esp_pkg::UPPER_W-1:0]     o_port_f_pullup_en,
    output logic                                 o_strobe_pullup_en
);

    // ------------------------------------------------------------------
    // Elaboration checks.
    // ------------------------------------------------------------------
    // The counter is eight bits wide; zero cycles would wrap LAST to 255 and strobe for 256.
    if (STROBE_CYCLES < 1 || STROBE_CYCLES > 255)
    begin : g_bad_cycles
        $error("STROBE_CYCLES must lie between 1 and 255");
    end

    localparam int UW = esp_pkg::UPPER_W;
    localparam int UL = esp_pkg::UPPER_LSB;
    localparam logic [esp_pkg::CNT_W-1:0] LAST =
        esp_pkg::CNT_W'(STROBE_CYCLES - 1);

    // ------------------------------------------------------------------
    // State.
    // ------------------------------------------------------------------
    esp_pkg::esp_state_type         state_q;   // Sequencer state.
    esp_pkg::esp_state_type         state_d;   // Its next value.
    logic [esp_pkg::CNT_W-1:0]      cnt_q;     // Strobe low cycles so far.
    esp_pkg::esp_req_type           req_q;     // Access under way.
    logic                           cs0_role_q;  // Zero select role.
    logic [UW-1:0]                  mode_q;    // One per pin: port F mode.
    logic [esp_pkg::DATA_W-1:0]     bus_out;   // Bus data before the mux.
    logic                           bus_oe;    // Bus drives the data lines.
    logic [UW-1:0]                  up_out;    // Upper pins after the mux.
    logic [UW-1:0]                  up_oe;     // Upper enables after mux.
    logic                           in_strobe; // Strobe low next cycle.
    logic                           drive_idle;  // Drive pins when idle.
    logic                           take;      // Request taken this edge.
    esp_pkg::esp_req_type           cur_req;   // Request the pins show.

    // ------------------------------------------------------------------
    // Sequencer next state.
    // ------------------------------------------------------------------
    // A request is taken only in idle, so the pins never see a new
    // access begin before the previous strobe has risen.
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            esp_pkg::ST_IDLE:
                if (take)
                begin
                    state_d = esp_pkg::ST_STROBE;
                end
            esp_pkg::ST_STROBE:
                if (cnt_q == LAST)
                begin
                    state_d = esp_pkg::ST_END;
                end
            esp_pkg::ST_END:
                state_d = esp_pkg::ST_IDLE;
            default:
                state_d = esp_pkg::ST_IDLE;
        endcase
    end

    assign in_strobe  = (state_d == esp_pkg::ST_STROBE);
    assign drive_idle = i_bus_drive_select;
    // Ready is a flop, so the edge just after reset refuses a request.
    assign take       = o_req_ready && i_req_valid;
    // The pins change on the taking edge, before req_q holds the request,
    // so the incoming request is used directly on that edge.
    assign cur_req    = take ? i_req : req_q;

    // ------------------------------------------------------------------
    // Sequencer registers.
    // ------------------------------------------------------------------
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            state_q <= esp_pkg::ST_IDLE;
            cnt_q   <= '0;
            req_q   <= '0;
        end
        else
        begin
            state_q <= state_d;
            // The count restarts each time a strobe begins.
            if (state_q == esp_pkg::ST_STROBE)
            begin
                cnt_q <= cnt_q + 1'b1;
            end
            else
            begin
                cnt_q <= '0;
            end
            if (take)
            begin
                req_q <= i_req;
            end
        end
    end

    // ------------------------------------------------------------------
    // Request handshake and read capture.
    // ------------------------------------------------------------------
    // The data pins are sampled on the edge that lifts the read strobe,
    // so the memory still drives them at the sampling instant.
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            o_req_ready <= 1'b0;
            o_done      <= 1'b0;
            o_rd_data   <= esp_pkg::DATA_RST;
        end
        else
        begin
            o_req_ready <= (state_d == esp_pkg::ST_IDLE);
            o_done      <= (state_q == esp_pkg::ST_STROBE) && !in_strobe;
            if (state_q == esp_pkg::ST_STROBE && !in_strobe && !req_q.write)
            begin
                o_rd_data <= i_data;  // [R2]
            end
        end
    end

    // ------------------------------------------------------------------
    // Configuration registers.
    // ------------------------------------------------------------------
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            cs0_role_q         <= esp_pkg::CS0_ROLE_PROG;  // [R8]
            mode_q             <= esp_pkg::MODE_RST;       // [R9]
            o_port_f_pullup_en <= esp_pkg::PULLUP_RST;
            o_strobe_pullup_en <= 1'b1;
        end
        else
        begin
            if (i_cs0_role_wr)
            begin
                cs0_role_q <= i_cs0_role;
            end
            if (i_mode_wr)
            begin
                mode_q <= i_mode;  // [R9]
            end
            if (i_pullup_wr)
            begin
                // Bit 0 is data line 7, bit 8 is data line 15.
                o_port_f_pullup_en <= i_pullup;  // [R10]
            end
            o_strobe_pullup_en <= !i_strobe_pud;  // [R11]
        end
    end

    // ------------------------------------------------------------------
    // Bus data before the port F mux.
    // ------------------------------------------------------------------
    // Store data stays on the bus through the end cycle, past the rising
    // edge of the store strobe, so the memory latches stable data.
    always_comb
    begin
        bus_out = cur_req.data;
        if (state_d == esp_pkg::ST_IDLE)
        begin
            bus_oe = drive_idle;  // [R6]
        end
        else
        begin
            bus_oe = cur_req.write;  // [R1] [R3] [R4]
        end
    end

    esp_upper_mux #(.WIDTH(UW)) u_upper_mux
    (
        .i_bus_out   (bus_out[UL +: UW]),
        .i_bus_oe    (bus_oe),
        .i_gpio_out  (i_port_f_out),
        .i_gpio_dir  (i_port_f_dir),
        .i_gpio_mode (mode_q),
        .o_pin_out   (up_out),
        .o_pin_oe    (up_oe)
    );

    // ------------------------------------------------------------------
    // Data pin registers.
    // ------------------------------------------------------------------
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            o_data      <= esp_pkg::DATA_RST;
            o_data_oe   <= '0;
            o_port_f_in <= '0;
        end
        else
        begin
            o_data[UL-1:0]     <= bus_out[UL-1:0];
            o_data_oe[UL-1:0]  <= {UL{bus_oe}};  // [R1] [R3]
            o_data[UL +: UW]    <= up_out;
            o_data_oe[UL +: UW] <= up_oe;
            o_port_f_in         <= i_data[UL +: UW];
        end
    end

    // ------------------------------------------------------------------
    // Strobe and select pin registers.
    // ------------------------------------------------------------------
    // Selects fall and rise together with the strobe, so they are never
    // seen active outside a strobe.
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            o_read_strobe_n      <= esp_pkg::STROBE_OFF;
            o_store_strobe_n     <= esp_pkg::STROBE_OFF;
            o_chip_select_zero_n <= esp_pkg::STROBE_OFF;
            o_data_select_n      <= esp_pkg::STROBE_OFF;
            o_strobe_oe          <= 1'b0;
            o_select_oe          <= 1'b0;
        end
        else
        begin
            o_read_strobe_n  <= (in_strobe && !cur_req.write) ?
                                esp_pkg::STROBE_ON : esp_pkg::STROBE_OFF;  // [R1]
            o_store_strobe_n <= (in_strobe && cur_req.write) ?
                                esp_pkg::STROBE_ON : esp_pkg::STROBE_OFF;  // [R3]
            o_chip_select_zero_n <=
                (in_strobe && cur_req.prog && cs0_role_q) ?
                esp_pkg::STROBE_ON : esp_pkg::STROBE_OFF;  // [R5] [R7] [R8]
            o_data_select_n  <= (in_strobe && !cur_req.prog) ?
                                esp_pkg::STROBE_ON : esp_pkg::STROBE_OFF;  // [R5] [R12]
            // Idle pins float unless drive select holds them high.
            o_strobe_oe <= (state_d != esp_pkg::ST_IDLE) || drive_idle;  // [R6] [R13]
            o_select_oe <= (state_d != esp_pkg::ST_IDLE) || drive_idle;  // [R6] [R13]
        end
    end

endmodule

// ### src/esp_upper_mux.sv
`timescale 1ns/1ps

// Selects, per upper data pin, between the memory bus and port F.
module esp_upper_mux
#(
    parameter int WIDTH = esp_pkg::UPPER_W
)
(
    // Memory bus side.
    input  wire logic [WIDTH-1:0] i_bus_out,
    input  wire logic             i_bus_oe,
    // Port F side.
    input  wire logic [WIDTH-1:0] i_gpio_out,
    input  wire logic [WIDTH-1:0] i_gpio_dir,
    input  wire logic [WIDTH-1:0] i_gpio_mode,
    // Pin side.
    output logic      [WIDTH-1:0] o_pin_out,
    output logic      [WIDTH-1:0] o_pin_oe
);

    // ------------------------------------------------------------------
    // Per pin selection.
    // ------------------------------------------------------------------
    // Each pin is handed over on its own, so a mixed setting is legal.
    for (genvar g = 0; g < WIDTH; g++)
    begin : g_pin
        assign o_pin_out[g] = i_gpio_mode[g] ? i_gpio_out[g] : i_bus_out[g];
        assign o_pin_oe[g]  = i_gpio_mode[g] ? i_gpio_dir[g] : i_bus_oe;
    end

endmodule
